// *** verilog/dpm_pkg.sv ***
// Package of register map, field layout, reset values and timing for the phase monitor block
package dpm_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_COARSE_WIN = 8'h74;
	localparam logic [7:0] ADDR_XIENT_MON  = 8'h76;
	localparam logic [7:0] ADDR_MEAS_LOW   = 8'h77;
	localparam logic [7:0] ADDR_MEAS_HIGH  = 8'h78;
	localparam logic [7:0] ADDR_ALARM_DLY  = 8'h79;
	localparam logic [7:0] ADDR_FRAME_OUT  = 8'h7a;
	localparam logic [7:0] ADDR_FRAME_ALGN = 8'h7b;

	// Reset values
	localparam logic [7:0] RST_COARSE_WIN  = 8'h85;
	localparam logic [7:0] RST_XIENT_MON   = 8'h06;
	localparam logic [7:0] RST_ALARM_DLY   = 8'h32;
	localparam logic [7:0] RST_FRAME_OUT   = 8'h00;
	localparam logic [7:0] RST_FRAME_ALGN  = 8'h00;

	// Writable bit masks, reserved bits read as zero
	localparam logic [7:0] MASK_COARSE_WIN = 8'hef;
	localparam logic [7:0] MASK_XIENT_MON  = 8'hbf;
	localparam logic [7:0] MASK_ALARM_DLY  = 8'h3f;
	localparam logic [7:0] MASK_FRAME_OUT  = 8'h8f;
	localparam logic [7:0] MASK_FRAME_ALGN = 8'hc3;

	// Coarse window register fields
	localparam int CW_LOSS_EN    = 7;
	localparam int CW_WIDE_EN    = 6;
	localparam int CW_MULTI_RESP = 5;
	localparam int CW_RANGE_LSB  = 0;

	// Transient monitor register fields
	localparam int XM_EDGE_GATE  = 7;
	localparam int XM_ENABLE     = 5;
	localparam int XM_BUILDOUT   = 4;
	localparam int XM_LIMIT_LSB  = 0;
	localparam logic [4:0] XM_LIMIT_BIAS = 5'h07;
	localparam int XM_STEP_PS    = 156250;

	// Alarm clear delay field
	localparam int AD_VALUE_LSB  = 0;

	// Frame pulse output register fields
	localparam int FP_SOURCE_SEL = 7;
	localparam int FP_8K_FLIP    = 3;
	localparam int FP_EIGHT_KHZ_PULSE_SHAPE   = 2;
	localparam int FP_2K_FLIP    = 1;
	localparam int FP_TWO_KHZ_PULSE_SHAPE   = 0;

	// Frame input alignment register fields
	localparam int FA_INDEP      = 7;
	localparam int FA_HIGH_RATE  = 6;
	localparam int FA_OFFSET_LSB = 0;

	// Timing: alarm clear unit and clock rate
	localparam int ALARM_UNIT_S  = 2;
	localparam int CLK_HZ        = 25000000;
	localparam int ALARM_UNIT_CYC = ALARM_UNIT_S * CLK_HZ;

	// External sync sampling precision
	typedef enum logic [1:0] {
		DPM_SAMPLE_6M48,
		DPM_SAMPLE_19M44,
		DPM_SAMPLE_38M88
	} dpm_sample_rate_t;

	// Frame shaper pulse state
	typedef enum logic {
		DPM_SH_IDLE,
		DPM_SH_PULSE
	} dpm_shape_state_t;
endpackage

// *** verilog/dpm_frame_shaper.sv ***
// Frame output shaper: square or single pulse with optional inversion
`timescale 1ns/1ps
module dpm_frame_shaper (
	input  wire logic i_ref_clk,
	input  wire logic i_rst,
	input  wire logic i_wave,
	input  wire logic i_pulse_mode,
	input  wire logic i_invert,
	input  wire logic i_ref_tick,
	output logic      o_out
);
	logic                      wave_q;
	logic                      armed_q;
	logic                      out_q;
	logic                      rise;
	logic                      launch;
	dpm_pkg::dpm_shape_state_t state_q;

	// Delay line for edge detection
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			wave_q <= 1'b0;
		end else begin
			wave_q <= i_wave;
		end
	end

	// Edge found, and pulse start at the next reference period boundary
	assign rise   = i_wave && !wave_q;
	assign launch = (rise || armed_q) && i_ref_tick;

	// An edge between boundaries is remembered until the boundary arrives
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			armed_q <= 1'b0;
		end else if (state_q == dpm_pkg::DPM_SH_IDLE && launch) begin
			armed_q <= 1'b0;
		end else if (rise) begin
			armed_q <= 1'b1;
		end
	end

	// Pulse runs boundary to boundary, so it is exactly one reference period wide
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= dpm_pkg::DPM_SH_IDLE;
		end else begin
			unique case (state_q)
				dpm_pkg::DPM_SH_IDLE: begin
					if (launch) begin
						state_q <= dpm_pkg::DPM_SH_PULSE;
					end
				end
				dpm_pkg::DPM_SH_PULSE: begin
					if (i_ref_tick) begin
						state_q <= dpm_pkg::DPM_SH_IDLE;
					end
				end
			endcase
		end
	end

	// Registered output with shape and polarity applied
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			out_q <= 1'b0;
		end else if (i_pulse_mode) begin
			out_q <= (state_q == dpm_pkg::DPM_SH_PULSE) ^ i_invert;
		end else begin
			out_q <= wave_q ^ i_invert;
		end
	end

	assign o_out = out_q;
endmodule

// *** verilog/dpm_phase_monitor.sv ***
// Phase monitor and frame sync configuration block with register port
//
// Summary of operation
// - Transient enable gates phase error threshold alarm
// - Transient alarm starts build-out when enabled
// - Alarm limit is (field plus 7) steps
// - Measured phase read as paired bytes
// - Rejected input alarm clears after 2-second units
// - Source bit picks main or aux path
// - 8 kHz polarity bit inverts frame output
// - 2 kHz polarity bit inverts multiframe output
// - 8 kHz shape: square or reference-wide pulse
// - 2 kHz shape: square or reference-wide pulse
// - Independence bit decouples frame outputs alignment
// - Low rate: 6.48 MHz sampling, no realign
// - High rate: realign, 19.44 or 38.88 MHz
// - Offset field shifts external sync sampling point
`timescale 1ns/1ps
module dpm_phase_monitor #(
	parameter int ALARM_UNIT_CYC = dpm_pkg::ALARM_UNIT_CYC
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_addr,
	input  wire logic        i_wr_stb,
	input  wire logic        i_rd_stb,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata,
	input  wire logic [7:0]  i_phase_err_mag,
	input  wire logic [15:0] i_meas_phase,
	input  wire logic        i_phase_reject,
	output logic             o_phase_alarm_hold,
	output logic             o_transient_alarm,
	output logic             o_buildout_start,
	input  wire logic        i_main_8k,
	input  wire logic        i_main_2k,
	input  wire logic        i_aux_8k,
	input  wire logic        i_aux_2k,
	input  wire logic        i_ref_out_tick,
	output logic             o_eight_khz_frame_out,
	output logic             o_two_khz_multiframe_out,
	input  wire logic        i_ref_is_19m44,
	output logic      [1:0]  o_sync_sample_rate,
	output logic             o_sync_realign_oc,
	output logic      [1:0]  o_sync_offset,
	output logic             o_frame_outputs_independent,
	output logic      [3:0]  o_coarse_track_range,
	output logic             o_coarse_loss_en,
	output logic             o_wide_range_en,
	output logic             o_multi_ph_resp,
	output logic             o_lowfreq_edge_gate
);
	logic [7:0]  coarse_win_q;
	logic [7:0]  xient_mon_q;
	logic [7:0]  alarm_dly_q;
	logic [7:0]  frame_out_q;
	logic [7:0]  frame_algn_q;
	logic [15:0] meas_q;
	logic [7:0]  meas_high_shadow_q;
	logic [7:0]  rdata_q;
	logic        xient_alarm_q;
	logic        xient_alarm_d;
	logic        buildout_q;
	logic [4:0]  xient_limit;
	logic [25:0] unit_cnt_q;
	logic        unit_tick;
	logic [5:0]  hold_cnt_q;
	logic        hold_q;
	logic        wave_8k;
	logic        wave_2k;
	logic [1:0]  sample_rate_q;

	// Write helper: keep only implemented bits
	function automatic logic [7:0] masked(input logic [7:0] data, input logic [7:0] mask);
		masked = data & mask;
	endfunction

	// Register writes at the documented offsets
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			coarse_win_q <= dpm_pkg::RST_COARSE_WIN;
			xient_mon_q  <= dpm_pkg::RST_XIENT_MON;
			alarm_dly_q  <= dpm_pkg::RST_ALARM_DLY;
			frame_out_q  <= dpm_pkg::RST_FRAME_OUT;
			frame_algn_q <= dpm_pkg::RST_FRAME_ALGN;
		end else if (i_wr_stb) begin
			unique case (i_addr)
				dpm_pkg::ADDR_COARSE_WIN: begin
					coarse_win_q <= masked(i_wdata, dpm_pkg::MASK_COARSE_WIN);
				end
				dpm_pkg::ADDR_XIENT_MON: begin
					xient_mon_q <= masked(i_wdata, dpm_pkg::MASK_XIENT_MON);
				end
				dpm_pkg::ADDR_ALARM_DLY: begin
					alarm_dly_q <= masked(i_wdata, dpm_pkg::MASK_ALARM_DLY);
				end
				dpm_pkg::ADDR_FRAME_OUT: begin
					frame_out_q <= masked(i_wdata, dpm_pkg::MASK_FRAME_OUT);
				end
				dpm_pkg::ADDR_FRAME_ALGN: begin
					frame_algn_q <= masked(i_wdata, dpm_pkg::MASK_FRAME_ALGN);
				end
				default: begin
				end
			endcase
		end
	end

	// Measured phase sampled each cycle from the phase detector average
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			meas_q <= 16'h0000;
		end else begin
			meas_q <= i_meas_phase;
		end
	end

	// Reading the low byte freezes the high byte so both halves match
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			meas_high_shadow_q <= 8'h00;
		end else if (i_rd_stb && i_addr == dpm_pkg::ADDR_MEAS_LOW) begin
			meas_high_shadow_q <= meas_q[15:8];
		end
	end

	// Registered read data, unmapped offsets return zero
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_q <= 8'h00;
		end else if (i_rd_stb) begin
			unique case (i_addr)
				dpm_pkg::ADDR_COARSE_WIN: rdata_q <= coarse_win_q;
				dpm_pkg::ADDR_XIENT_MON:  rdata_q <= xient_mon_q;
				dpm_pkg::ADDR_MEAS_LOW:   rdata_q <= meas_q[7:0];
				dpm_pkg::ADDR_MEAS_HIGH:  rdata_q <= meas_high_shadow_q;
				dpm_pkg::ADDR_ALARM_DLY:  rdata_q <= alarm_dly_q;
				dpm_pkg::ADDR_FRAME_OUT:  rdata_q <= frame_out_q;
				dpm_pkg::ADDR_FRAME_ALGN: rdata_q <= frame_algn_q;
				default:                  rdata_q <= 8'h00;
			endcase
		end
	end

	assign o_rdata = rdata_q;

	// Transient limit in 156.25 ns steps
	assign xient_limit = {1'b0, xient_mon_q[dpm_pkg::XM_LIMIT_LSB +: 4]} + dpm_pkg::XM_LIMIT_BIAS;

	// Alarm only while the monitor is enabled and the error exceeds the limit
	assign xient_alarm_d = xient_mon_q[dpm_pkg::XM_ENABLE] &&
		({3'b000, xient_limit} < i_phase_err_mag);

	// Alarm level and build-out start pulse on the alarm's rising edge
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			xient_alarm_q <= 1'b0;
			buildout_q    <= 1'b0;
		end else begin
			xient_alarm_q <= xient_alarm_d;
			buildout_q    <= xient_alarm_d && !xient_alarm_q &&
				xient_mon_q[dpm_pkg::XM_BUILDOUT];
		end
	end

	assign o_transient_alarm = xient_alarm_q;
	assign o_buildout_start  = buildout_q;

	// Divider giving one enable pulse per alarm clear unit
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			unit_cnt_q <= 26'h0000000;
		end else if (unit_tick) begin
			unit_cnt_q <= 26'h0000000;
		end else begin
			unit_cnt_q <= unit_cnt_q + 26'h0000001;
		end
	end

	assign unit_tick = (unit_cnt_q == 26'(ALARM_UNIT_CYC - 1));

	// Rejected input stays alarmed until the programmed number of unit ticks, and at least one, has passed; a new reject wins
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			hold_q     <= 1'b0;
			hold_cnt_q <= 6'h00;
		end else if (i_phase_reject) begin
			hold_q     <= 1'b1;
			hold_cnt_q <= alarm_dly_q[dpm_pkg::AD_VALUE_LSB +: 6];
		end else if (hold_q && unit_tick) begin
			if (hold_cnt_q <= 6'h01) begin
				hold_q     <= 1'b0;
				hold_cnt_q <= 6'h00;
			end else begin
				hold_cnt_q <= hold_cnt_q - 6'h01;
			end
		end
	end

	assign o_phase_alarm_hold = hold_q;

	// Frame pulse source: main path at zero, aux path at one
	assign wave_8k = frame_out_q[dpm_pkg::FP_SOURCE_SEL] ? i_aux_8k : i_main_8k;
	assign wave_2k = frame_out_q[dpm_pkg::FP_SOURCE_SEL] ? i_aux_2k : i_main_2k;

	// 8 kHz frame output shaping and polarity
	dpm_frame_shaper u_shape_8k (
		.i_ref_clk    (i_ref_clk),
		.i_rst        (i_rst),
		.i_wave       (wave_8k),
		.i_pulse_mode (frame_out_q[dpm_pkg::FP_EIGHT_KHZ_PULSE_SHAPE]),
		.i_invert     (frame_out_q[dpm_pkg::FP_8K_FLIP]),
		.i_ref_tick   (i_ref_out_tick),
		.o_out        (o_eight_khz_frame_out)
	);

	// 2 kHz multiframe output shaping and polarity
	dpm_frame_shaper u_shape_2k (
		.i_ref_clk    (i_ref_clk),
		.i_rst        (i_rst),
		.i_wave       (wave_2k),
		.i_pulse_mode (frame_out_q[dpm_pkg::FP_TWO_KHZ_PULSE_SHAPE]),
		.i_invert     (frame_out_q[dpm_pkg::FP_2K_FLIP]),
		.i_ref_tick   (i_ref_out_tick),
		.o_out        (o_two_khz_multiframe_out)
	);

	// External sync sampling precision from rate bit and reference rate
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			sample_rate_q <= dpm_pkg::DPM_SAMPLE_6M48;
		end else if (!frame_algn_q[dpm_pkg::FA_HIGH_RATE]) begin
			sample_rate_q <= dpm_pkg::DPM_SAMPLE_6M48;
		end else if (i_ref_is_19m44) begin
			sample_rate_q <= dpm_pkg::DPM_SAMPLE_19M44;
		end else begin
			sample_rate_q <= dpm_pkg::DPM_SAMPLE_38M88;
		end
	end

	assign o_sync_sample_rate = sample_rate_q;

	// Configuration handed to the DPLL core and sync aligner
	assign o_sync_realign_oc           = frame_algn_q[dpm_pkg::FA_HIGH_RATE];
	assign o_sync_offset               = frame_algn_q[dpm_pkg::FA_OFFSET_LSB +: 2];
	assign o_frame_outputs_independent = frame_algn_q[dpm_pkg::FA_INDEP];
	assign o_coarse_track_range        = coarse_win_q[dpm_pkg::CW_RANGE_LSB +: 4];
	assign o_coarse_loss_en            = coarse_win_q[dpm_pkg::CW_LOSS_EN];
	assign o_wide_range_en             = coarse_win_q[dpm_pkg::CW_WIDE_EN];
	assign o_multi_ph_resp             = coarse_win_q[dpm_pkg::CW_MULTI_RESP];
	assign o_lowfreq_edge_gate         = xient_mon_q[dpm_pkg::XM_EDGE_GATE];

	// Checks on the block's own registers and outputs
	default clocking dpm_cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	sequence low_byte_read_s;
		i_rd_stb && i_addr == dpm_pkg::ADDR_MEAS_LOW;
	endsequence

	sequence high_byte_read_s;
		i_rd_stb && i_addr == dpm_pkg::ADDR_MEAS_HIGH && !i_wr_stb;
	endsequence

	sequence frame_cfg_write_s;
		i_wr_stb && i_addr == dpm_pkg::ADDR_FRAME_OUT;
	endsequence

	sequence monitor_write_s;
		i_wr_stb && i_addr == dpm_pkg::ADDR_XIENT_MON;
	endsequence

	sequence delay_write_s;
		i_wr_stb && i_addr == dpm_pkg::ADDR_ALARM_DLY;
	endsequence

	// Register writes land the next cycle with reserved bits cleared
	monitor_write_a: assert property (
		monitor_write_s |=> xient_mon_q == ($past(i_wdata) & dpm_pkg::MASK_XIENT_MON))
		else $error("transient monitor register write not applied");

	delay_write_a: assert property (
		delay_write_s |=> alarm_dly_q == ($past(i_wdata) & dpm_pkg::MASK_ALARM_DLY))
		else $error("alarm clear delay register write not applied");

	frame_write_a: assert property (
		frame_cfg_write_s |=> frame_out_q == ($past(i_wdata) & dpm_pkg::MASK_FRAME_OUT))
		else $error("frame pulse register write not applied");

	meas_low_a: assert property (
		low_byte_read_s |=> o_rdata == $past(meas_q[7:0]))
		else $error("low phase byte not returned");

	xient_raise_a: assert property (
		(xient_mon_q[dpm_pkg::XM_ENABLE] && i_phase_err_mag > {3'b000, xient_limit})
		|=> o_transient_alarm)
		else $error("transient alarm not raised above limit");

	xient_off_a: assert property (
		!xient_mon_q[dpm_pkg::XM_ENABLE] |=> !o_transient_alarm)
		else $error("transient alarm raised while monitor disabled");

	xient_limit_a: assert property (
		o_transient_alarm |-> $past(i_phase_err_mag) >
		{3'b000, 1'b0, $past(xient_mon_q[3:0])} + 8'h07)
		else $error("transient alarm at or below programmed limit");

	buildout_start_a: assert property (
		$rose(o_transient_alarm) && $past(xient_mon_q[dpm_pkg::XM_BUILDOUT]) |-> o_buildout_start)
		else $error("build-out not started by transient alarm");

	buildout_quiet_a: assert property (
		o_buildout_start |-> $rose(o_transient_alarm) && $past(xient_mon_q[dpm_pkg::XM_BUILDOUT]))
		else $error("build-out started without enabled transient alarm");

	buildout_pulse_a: assert property (
		o_buildout_start |=> !o_buildout_start)
		else $error("build-out start longer than one cycle");

	phase_pair_a: assert property (
		(low_byte_read_s ##1 high_byte_read_s) |=> o_rdata == $past(meas_q[15:8], 2))
		else $error("high phase byte not paired with low byte read");

	// Delays of zero or one unit may clear at the very next tick
	alarm_hold_a: assert property (
		i_phase_reject && alarm_dly_q[dpm_pkg::AD_VALUE_LSB +: 6] > 6'h01
		|=> o_phase_alarm_hold [*2])
		else $error("rejected input alarm not held");

	hold_count_a: assert property (
		i_phase_reject |=> o_phase_alarm_hold &&
		hold_cnt_q == $past(alarm_dly_q[dpm_pkg::AD_VALUE_LSB +: 6]))
		else $error("rejected input hold not loaded from delay field");

	alarm_clear_a: assert property (
		$fell(o_phase_alarm_hold) |-> $past(unit_tick) && $past(hold_cnt_q) <= 6'h01)
		else $error("alarm cleared outside a unit boundary");

	frame_square_a: assert property (
		!frame_out_q[dpm_pkg::FP_EIGHT_KHZ_PULSE_SHAPE] && $stable(frame_out_q) [*3] |->
		o_eight_khz_frame_out == ($past(wave_8k, 2) ^ frame_out_q[dpm_pkg::FP_8K_FLIP]))
		else $error("8 kHz square output wrong polarity or source");

	multi_square_a: assert property (
		!frame_out_q[dpm_pkg::FP_TWO_KHZ_PULSE_SHAPE] && $stable(frame_out_q) [*3] |->
		o_two_khz_multiframe_out == ($past(wave_2k, 2) ^ frame_out_q[dpm_pkg::FP_2K_FLIP]))
		else $error("2 kHz square output wrong polarity");

	sync_rate_a: assert property (
		##1 o_sync_sample_rate == (!$past(frame_algn_q[dpm_pkg::FA_HIGH_RATE]) ?
		dpm_pkg::DPM_SAMPLE_6M48 : ($past(i_ref_is_19m44) ?
		dpm_pkg::DPM_SAMPLE_19M44 : dpm_pkg::DPM_SAMPLE_38M88)))
		else $error("external sync sampling rate wrong");
endmodule

// *** testbench/dpm_wave_source.sv ***
// Stand-in for the output timing paths: frame waves and reference output ticks
`timescale 1ns/1ps
module dpm_wave_source (
	input  wire logic i_ref_clk,
	input  wire logic i_rst,
	output logic      o_main_8k,
	output logic      o_main_2k,
	output logic      o_aux_8k,
	output logic      o_aux_2k,
	output logic      o_ref_out_tick
);
	logic [5:0] cnt_q;

	// Free-running divider: 8 kHz half period 8 cycles, 2 kHz half period 32
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= 6'h00;
		end else begin
			cnt_q <= cnt_q + 6'h01;
		end
	end

	// Aux path in antiphase so that a wrong source choice always shows
	assign o_main_8k      = cnt_q[3];
	assign o_main_2k      = cnt_q[5];
	assign o_aux_8k       = ~cnt_q[3];
	assign o_aux_2k       = ~cnt_q[5];
	// Reference output period of four cycles sets the pulse width
	assign o_ref_out_tick = (cnt_q[1:0] == 2'h3);
endmodule

// *** testbench/dpm_phase_monitor_bench.sv ***
// Self-checking bench for the phase monitor and frame sync block
`timescale 1ns/1ps
`define CHK(act, exp) check_val(act, exp)
module dpm_phase_monitor_bench;
	localparam int UNIT = 16;
	logic        clk, rst, wr, rd, rej, r19;
	logic [7:0]  addr, wdata, mag, rdata;
	logic [15:0] meas;
	logic        hold, xalarm, bo, m8, m2, a8, a2, tick, out8, out2;
	logic        realign, indep, loss_en, wide_en, multi, gate;
	logic [1:0]  rate, offs;
	logic [3:0]  crange;
	int          fail_count, tests_run;
	logic [7:0]  ra [5] = '{8'h74, 8'h76, 8'h79, 8'h7a, 8'h7b};
	logic [7:0]  rv [5] = '{8'h85, 8'h06, 8'h32, 8'h00, 8'h00};
	logic [7:0]  rm [5] = '{8'hef, 8'hbf, 8'h3f, 8'h8f, 8'hc3};

	dpm_phase_monitor #(.ALARM_UNIT_CYC(UNIT)) DUT (
		.i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wr_stb(wr), .i_rd_stb(rd),
		.i_wdata(wdata), .o_rdata(rdata), .i_phase_err_mag(mag), .i_meas_phase(meas),
		.i_phase_reject(rej), .o_phase_alarm_hold(hold), .o_transient_alarm(xalarm),
		.o_buildout_start(bo), .i_main_8k(m8), .i_main_2k(m2), .i_aux_8k(a8),
		.i_aux_2k(a2), .i_ref_out_tick(tick), .o_eight_khz_frame_out(out8),
		.o_two_khz_multiframe_out(out2), .i_ref_is_19m44(r19), .o_sync_sample_rate(rate),
		.o_sync_realign_oc(realign), .o_sync_offset(offs),
		.o_frame_outputs_independent(indep), .o_coarse_track_range(crange),
		.o_coarse_loss_en(loss_en), .o_wide_range_en(wide_en), .o_multi_ph_resp(multi),
		.o_lowfreq_edge_gate(gate));

	dpm_wave_source u_src (.i_ref_clk(clk), .i_rst(rst), .o_main_8k(m8), .o_main_2k(m2),
		.o_aux_8k(a8), .o_aux_2k(a2), .o_ref_out_tick(tick));

	// Clock generation, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check_val(input logic [15:0] act, input logic [15:0] exp);
		tests_run++;
		if (act !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp);
		end
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// One write cycle on the strobe port
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	// One read cycle, data taken once the read edge has landed
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic wait_settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Defaults, writable masks and an unmapped address
	task automatic t_regs();
		logic [7:0] d;
		for (int i = 0; i < 5; i++) begin
			reg_rd(ra[i], d);
			`CHK(d, rv[i]);
			reg_wr(ra[i], 8'hff);
			reg_rd(ra[i], d);
			`CHK(d, rm[i]);
			reg_wr(ra[i], rv[i]);
		end
		reg_wr(8'h75, 8'hff);
		reg_rd(8'h75, d);
		`CHK(d, 8'h00);
	endtask

	// Paired bytes, writes ignored, high byte from the low-read snapshot
	task automatic t_meas();
		logic [7:0] d;
		@(posedge clk);
		meas <= 16'h8a3c;
		reg_wr(8'h77, 8'h55);
		reg_wr(8'h78, 8'h55);
		reg_rd(8'h77, d);
		`CHK(d, 8'h3c);
		@(posedge clk);
		meas <= 16'h1177;
		reg_rd(8'h78, d);
		`CHK(d, 8'h8a);
		// Back-to-back low then high read while the phase moves on
		@(posedge clk);
		meas <= 16'h5e21;
		@(posedge clk);
		addr <= 8'h77;
		rd   <= 1'b1;
		@(posedge clk);
		addr <= 8'h78;
		meas <= 16'h0000;
		#1;
		`CHK(rdata, 8'h21);
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		`CHK(rdata, 8'h5e);
	endtask

	// Apply one error level and count build-out pulses
	task automatic xient_probe(input logic [7:0] ctl, input logic [7:0] m,
		input logic exp_a, input int exp_bo);
		int n;
		n = 0;
		reg_wr(8'h76, ctl);
		@(posedge clk);
		mag <= m;
		repeat (4) begin
			@(posedge clk);
			#1;
			if (bo === 1'b1) n++;
		end
		`CHK(xalarm, exp_a);
		`CHK(n, exp_bo);
		@(posedge clk);
		mag <= 8'h00;
		wait_settle(3);
	endtask

	// Rejected input held for two to three units of the delay field
	task automatic t_hold();
		reg_wr(8'h79, 8'h03);
		@(posedge clk);
		rej <= 1'b1;
		@(posedge clk);
		rej <= 1'b0;
		wait_settle(2 * UNIT - 2);
		`CHK(hold, 1'b1);
		wait_settle(UNIT + 4);
		`CHK(hold, 1'b0);
	endtask

	// Square mode for every source and polarity combination
	task automatic t_square();
		for (int i = 0; i < 8; i++) begin
			reg_wr(8'h7a, {i[2], 3'h0, i[1], 1'b0, i[0], 1'b0});
			@(posedge m8);
			wait_settle(4);
			`CHK(out8, (i[2] ? a8 : m8) ^ i[1]);
			@(posedge m2);
			wait_settle(4);
			`CHK(out2, (i[2] ? a2 : m2) ^ i[0]);
		end
	endtask

	// Pulse mode: exactly one four-cycle reference period wide, then idle level
	task automatic t_pulse();
		int n;
		for (int i = 0; i < 2; i++) begin
			reg_wr(8'h7a, {4'h0, i[0], 1'b1, i[0], 1'b1});
			n = 0;
			@(posedge m8);
			repeat (12) begin
				@(posedge clk);
				#1;
				if (out8 !== i[0]) n++;
			end
			`CHK(n, 16'h0004);
			`CHK(out8, i[0]);
			n = 0;
			@(posedge m2);
			repeat (12) begin
				@(posedge clk);
				#1;
				if (out2 !== i[0]) n++;
			end
			`CHK(n, 16'h0004);
			`CHK(out2, i[0]);
		end
	endtask

	// Sync sampling choices and exported configuration fields
	task automatic t_sync();
		reg_wr(8'h7b, 8'h02);
		@(posedge clk);
		r19 <= 1'b1;
		wait_settle(3);
		`CHK({realign, rate}, 3'h0);
		`CHK({indep, offs}, 3'h2);
		reg_wr(8'h7b, 8'hc1);
		wait_settle(3);
		`CHK({realign, rate}, 3'h5);
		`CHK({indep, offs}, 3'h5);
		@(posedge clk);
		r19 <= 1'b0;
		wait_settle(3);
		`CHK(rate, 2'h2);
		reg_wr(8'h74, 8'h6a);
		reg_wr(8'h76, 8'h80);
		wait_settle(2);
		`CHK({loss_en, wide_en, multi, crange}, 7'h3a);
		`CHK(gate, 1'b1);
	endtask

	// Main sequence
	initial begin
		fail_count = 0;
		tests_run = 0;
		rst = 1'b1;
		{wr, rd, rej, r19} = 4'h0;
		addr = 8'h00;
		wdata = 8'h00;
		mag = 8'h00;
		meas = 16'h0000;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_meas();
		xient_probe(8'h36, 8'd13, 1'b0, 0);
		xient_probe(8'h36, 8'd14, 1'b1, 1);
		xient_probe(8'h26, 8'd14, 1'b1, 0);
		xient_probe(8'h16, 8'hff, 1'b0, 0);
		xient_probe(8'h30, 8'd7, 1'b0, 0);
		xient_probe(8'h30, 8'd8, 1'b1, 1);
		xient_probe(8'h2f, 8'd22, 1'b0, 0);
		xient_probe(8'h2f, 8'd23, 1'b1, 0);
		t_hold();
		t_square();
		t_pulse();
		t_sync();
		stop_test();
	end

	// Watchdog well beyond the thousand or so cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		stop_test();
	end
endmodule
